//--- fpm_pkg.sv
// What this block does
// - Light everything briefly at power up
// - Remote indicator lit under remote control
// - Return key leaves remote, clears indicator
// - Interface lamps follow fitted options
// - Normal message after power up
// - Wake-up or auto selection changes message
// - Normal mode shows bank and state
// - Fifteen banks stepped by upper arrows
// - Ten states stepped by lower arrows
// - Auto mode upper digits show settle time
// - Settle time 0.1 to 9.9 s, 100 ms
// - No fail flag while settle time runs
// - Out of limits in window halts, flashes flag
// - Halted: enter resumes next, exit aborts
// - Arrows adjust the value being shown
package fpm_pkg;

  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int CLK_HZ = 50_000_000; // System clock rate in hertz.
  localparam int TICK_MS = 100; // Length of one timer tick in milliseconds.
  localparam int TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS; // Clock cycles per tick.
  localparam logic [3:0] LAMP_TICKS = 4'hA; // Display check length in ticks.

  // ************************************************************
  // Value ranges, in display units.
  // ************************************************************
  localparam logic [3:0] BANK_MIN = 4'h1; // First memory bank.
  localparam logic [3:0] BANK_MAX = 4'hF; // Last memory bank.
  localparam logic [3:0] STATE_MIN = 4'h1; // First memory state.
  localparam logic [3:0] STATE_MAX = 4'hA; // Last memory state.
  localparam logic [6:0] TIME_MIN = 7'h01; // Shortest time, in tenths of a second.
  localparam logic [6:0] TIME_MAX = 7'h63; // Longest time, in tenths of a second.
  localparam logic [6:0] TIME_RST = 7'h0A; // Time after reset, one second.
  localparam logic [3:0] STEPS_RST = 4'hA; // Steps in a sequence after reset.

  // ************************************************************
  // Register map and fields.
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00; // Control register.
  localparam logic [7:0] OFS_STATUS = 8'h04; // Event status, cleared by read.
  localparam logic [7:0] OFS_MASK = 8'h08; // Interrupt mask.
  localparam logic [7:0] OFS_VIEW = 8'h0C; // Live selection and sequence view.
  localparam int CTRL_FAIL_EN = 0; // Enables fail flagging.
  localparam int CTRL_STEPS_LSB = 4; // Sequence step count field.
  localparam int EV_FAIL = 0; // A step failed its limits.
  localparam int EV_DONE = 1; // A sequence ran to its end or was aborted.
  localparam int EV_LOCAL = 2; // Return key took control back from remote.
  localparam int EV_W = 3; // Number of event bits.
  localparam logic [1:0] RESP_OKAY = 2'h0; // Bus answer for a mapped address.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Bus answer for an unmapped address.

  // ************************************************************
  // Types.
  // ************************************************************
  typedef enum logic [1:0] {MSG_NORMAL, MSG_WAKE, MSG_AUTO} fpm_msg_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_SETTLE, SQ_CHECK, SQ_HALT} fpm_seq_t;

  // Front-panel key presses, each a one-cycle pulse.
  typedef struct packed {
    logic up_inc;
    logic up_dec;
    logic low_inc;
    logic low_dec;
    logic enter;
    logic exit_key;
    logic test;
    logic local_key;
    logic wake_sel;
    logic auto_sel;
  } fpm_keys_t;

  // Everything the display shows.
  typedef struct packed {
    logic all_on;
    logic remote_indicator;
    logic [3:0] iface_lamps;
    fpm_msg_t status_msg;
    logic [6:0] upper_value;
    logic [6:0] lower_value;
    logic fail_flag;
    logic running;
  } fpm_disp_t;

endpackage

//--- fpm_front_panel.sv
`timescale 1ns/1ps
module fpm_front_panel
#(
  parameter int TICK_CYCLES = fpm_pkg::TICK_CYCLES_DEF // Cycles per 100 ms tick.
)
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire fpm_pkg::fpm_keys_t keys, // Key press pulses.
  input wire logic remote_req, // Pulse: a remote interface took control.
  input wire logic [3:0] iface_fitted, // Fitted interface options.
  input wire logic limit_fail, // Measurement outside the step limits.
  output fpm_pkg::fpm_disp_t disp_q, // Display contents.
  output logic irq // Level interrupt.
);
  import fpm_pkg::*;

  if (TICK_CYCLES < 2)
  begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // ************************************************************
  // Tick and display check.
  // ************************************************************
  logic [31:0] tick_cnt_q; // Cycles into the current tick.
  logic tick; // One-cycle pulse every 100 ms.
  logic [3:0] lamp_q; // Ticks of display check left.
  logic lamp_on; // Display check running.

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign lamp_on = (lamp_q != 4'h0);

  // The tick divider runs free so every timer shares one time base.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  // The display check starts at reset and lasts a fixed number of ticks.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lamp_q <= LAMP_TICKS;
    else if (lamp_on && tick)
      lamp_q <= lamp_q - 4'h1;
  end

  // ************************************************************
  // Remote control and mode.
  // ************************************************************
  logic remote_q; // Load is under remote control.
  fpm_msg_t msg_q; // Selected status message.
  fpm_seq_t seq_q; // Auto-sequence state.
  logic panel_ok; // Front panel keys are honoured.

  assign panel_ok = !remote_q && !lamp_on;

  // A remote request in the same cycle as the return key wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      remote_q <= 1'b0;
    else if (remote_req)
      remote_q <= 1'b1;
    else if (keys.local_key)
      remote_q <= 1'b0;
  end

  // Mode changes are refused while a sequence runs so timing stays intact.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      msg_q <= MSG_NORMAL;
    else if (panel_ok && seq_q == SQ_IDLE)
    begin
      if (keys.auto_sel)
        msg_q <= MSG_AUTO;
      else if (keys.wake_sel)
        msg_q <= MSG_WAKE;
      else if (keys.exit_key)
        msg_q <= MSG_NORMAL;
    end
  end

  // ************************************************************
  // Selections and times.
  // ************************************************************
  logic [3:0] bank_q; // Selected memory bank.
  logic [3:0] state_q; // Selected memory state.
  logic [6:0] settle_q; // Settle time in tenths.
  logic [6:0] check_q; // Check window time in tenths.
  logic adj_sel; // Arrows steer bank and state.
  logic adj_time; // Arrows steer the two times.

  assign adj_sel = panel_ok && msg_q != MSG_AUTO;
  assign adj_time = panel_ok && msg_q == MSG_AUTO && seq_q == SQ_IDLE;

  // Bank steps by the upper arrows and saturates at both ends.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bank_q <= BANK_MIN;
    else if (adj_sel && keys.up_inc && bank_q != BANK_MAX)
      bank_q <= bank_q + 4'h1;
    else if (adj_sel && keys.up_dec && bank_q != BANK_MIN)
      bank_q <= bank_q - 4'h1;
  end

  // State steps by the lower arrows and saturates at both ends.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= STATE_MIN;
    else if (adj_sel && keys.low_inc && state_q != STATE_MAX)
      state_q <= state_q + 4'h1;
    else if (adj_sel && keys.low_dec && state_q != STATE_MIN)
      state_q <= state_q - 4'h1;
  end

  // Settle time moves in 100 ms steps within its range.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      settle_q <= TIME_RST;
    else if (adj_time && keys.up_inc && settle_q != TIME_MAX)
      settle_q <= settle_q + 7'h01;
    else if (adj_time && keys.up_dec && settle_q != TIME_MIN)
      settle_q <= settle_q - 7'h01;
  end

  // Check window uses the same range and step as the settle time.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      check_q <= TIME_RST;
    else if (adj_time && keys.low_inc && check_q != TIME_MAX)
      check_q <= check_q + 7'h01;
    else if (adj_time && keys.low_dec && check_q != TIME_MIN)
      check_q <= check_q - 7'h01;
  end

  // ************************************************************
  // Auto-sequence.
  // ************************************************************
  logic fail_en_q; // Fail flagging enabled by software.
  logic [3:0] steps_q; // Steps in one sequence.
  logic [3:0] step_q; // Current step, counted from zero.
  logic [6:0] tmr_q; // Ticks left in the current phase.
  logic blink_q; // Flash phase of the fail flag.
  logic last_step; // Current step is the final one.
  logic phase_end; // Current timed phase expires now.
  logic ev_fail; // Pulse: a step failed.
  logic ev_done; // Pulse: a sequence ended.

  assign last_step = (step_q + 4'h1 >= steps_q);
  assign phase_end = tick && tmr_q == 7'h01;
  assign ev_fail = seq_q == SQ_CHECK && fail_en_q && limit_fail;
  assign ev_done = (seq_q == SQ_CHECK && !ev_fail && phase_end && last_step)
    || (seq_q == SQ_HALT && keys.exit_key)
    || (seq_q == SQ_HALT && keys.enter && last_step);

  // Each step settles first, then checks limits, then moves on.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_q <= SQ_IDLE;
      step_q <= 4'h0;
      tmr_q <= TIME_MIN;
    end
    else
    begin
      case (seq_q)
        SQ_IDLE:
        begin
          if (panel_ok && msg_q == MSG_AUTO && keys.test)
          begin
            seq_q <= SQ_SETTLE;
            step_q <= 4'h0;
            tmr_q <= settle_q;
          end
        end
        SQ_SETTLE:
        begin
          if (phase_end)
          begin
            seq_q <= SQ_CHECK;
            tmr_q <= check_q;
          end
          else if (tick)
            tmr_q <= tmr_q - 7'h01;
        end
        SQ_CHECK:
        begin
          if (ev_fail)
            seq_q <= SQ_HALT;
          else if (phase_end && last_step)
            seq_q <= SQ_IDLE;
          else if (phase_end)
          begin
            seq_q <= SQ_SETTLE;
            step_q <= step_q + 4'h1;
            tmr_q <= settle_q;
          end
          else if (tick)
            tmr_q <= tmr_q - 7'h01;
        end
        SQ_HALT:
        begin
          if (keys.exit_key)
            seq_q <= SQ_IDLE;
          else if (keys.enter && last_step)
            seq_q <= SQ_IDLE;
          else if (keys.enter)
          begin
            seq_q <= SQ_SETTLE;
            step_q <= step_q + 4'h1;
            tmr_q <= settle_q;
          end
        end
        default:
          seq_q <= SQ_IDLE;
      endcase
    end
  end

  // The flag flashes at the tick rate while halted, lights for the display check and is dark otherwise.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || seq_q != SQ_HALT)
      blink_q <= 1'b1;
    else if (tick)
      blink_q <= !blink_q;
  end

  // ************************************************************
  // Display register.
  // ************************************************************
  // One register stage keeps the display free of decode glitches.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      disp_q <= '0;
    else
    begin
      disp_q.all_on <= lamp_on;
      disp_q.remote_indicator <= remote_q || lamp_on;
      disp_q.iface_lamps <= lamp_on ? 4'hF : iface_fitted;
      disp_q.status_msg <= msg_q;
      disp_q.upper_value <= (msg_q == MSG_AUTO) ? settle_q : {3'h0, bank_q};
      disp_q.lower_value <= (msg_q == MSG_AUTO) ? check_q : {3'h0, state_q};
      disp_q.fail_flag <= lamp_on || (seq_q == SQ_HALT && blink_q);
      disp_q.running <= seq_q != SQ_IDLE;
    end
  end

  // ************************************************************
  // Register bus and interrupt.
  // ************************************************************
  logic aw_q; // Write address held.
  logic w_q; // Write data held.
  logic [7:0] awaddr_q; // Held write address.
  logic [31:0] wdata_q; // Held write data.
  logic [3:0] wstrb_q; // Held write strobes.
  logic [EV_W-1:0] sts_q; // Sticky events.
  logic [EV_W-1:0] mask_q; // Interrupt mask.
  logic do_wr; // Write commits this cycle.
  logic do_rd; // Read taken this cycle.
  logic rd_sts; // Read of the status register.
  logic [EV_W-1:0] ev; // Event pulses.

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_q && w_q && !s_axi_bvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign rd_sts = do_rd && s_axi_araddr == OFS_STATUS;
  assign ev = {remote_q && !remote_req && keys.local_key, ev_done, ev_fail};
  assign irq = |(sts_q & mask_q);

  // Address and data are caught separately, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_MASK || awaddr_q == OFS_STATUS
          || awaddr_q == OFS_VIEW) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask take byte lane zero only; the rest read back as zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fail_en_q <= 1'b1;
      steps_q <= STEPS_RST;
      mask_q <= '0;
    end
    else if (do_wr && wstrb_q[0])
    begin
      if (awaddr_q == OFS_CTRL)
      begin
        fail_en_q <= wdata_q[CTRL_FAIL_EN];
        steps_q <= (wdata_q[CTRL_STEPS_LSB +: 4] == 4'h0) ? 4'h1 : wdata_q[CTRL_STEPS_LSB +: 4];
      end
      if (awaddr_q == OFS_MASK)
        mask_q <= wdata_q[EV_W-1:0];
    end
  end

  // A new event in the cycle of the clearing read survives the read.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sts_q <= '0;
    else
      sts_q <= (rd_sts ? '0 : sts_q) | ev;
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (do_rd)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= {24'h00_0000, steps_q, 3'h0, fail_en_q};
        OFS_STATUS: s_axi_rdata <= {29'h0000_0000, sts_q};
        OFS_MASK: s_axi_rdata <= {29'h0000_0000, mask_q};
        OFS_VIEW: s_axi_rdata <= {2'h0, 2'(seq_q), step_q, state_q, bank_q, 1'b0, check_q,
          1'b0, settle_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  property p_lamp;
    @(posedge aclk) disable iff (!aresetn) lamp_on |=> disp_q.all_on && disp_q.fail_flag;
  endproperty
  a_lamp: assert property (p_lamp) else $error("display check not lit");

  property p_rem_set;
    @(posedge aclk) disable iff (!aresetn) remote_req |=> ##1 disp_q.remote_indicator;
  endproperty
  a_rem_set: assert property (p_rem_set) else $error("remote not shown");

  property p_local_clr;
    @(posedge aclk) disable iff (!aresetn)
      keys.local_key && !remote_req && !lamp_on |=> !remote_q ##1 !disp_q.remote_indicator;
  endproperty
  a_local_clr: assert property (p_local_clr) else $error("return key ignored");

  property p_iface;
    @(posedge aclk) disable iff (!aresetn)
      !lamp_on |=> disp_q.iface_lamps == $past(iface_fitted);
  endproperty
  a_iface: assert property (p_iface) else $error("interface lamps wrong");

  property p_bank_step;
    @(posedge aclk) disable iff (!aresetn)
      adj_sel && keys.up_inc && bank_q != BANK_MAX |=> bank_q == $past(bank_q) + 4'h1;
  endproperty
  a_bank_step: assert property (p_bank_step) else $error("bank did not step");

  property p_range;
    @(posedge aclk) disable iff (!aresetn) bank_q >= BANK_MIN && bank_q <= BANK_MAX
      && state_q >= STATE_MIN && state_q <= STATE_MAX && settle_q >= TIME_MIN
      && settle_q <= TIME_MAX;
  endproperty
  a_range: assert property (p_range) else $error("selection out of range");

  property p_settle_nofail;
    @(posedge aclk) disable iff (!aresetn)
      seq_q == SQ_SETTLE && !lamp_on |=> !disp_q.fail_flag;
  endproperty
  a_settle_nofail: assert property (p_settle_nofail) else $error("flag in settle");

  property p_settle_end;
    @(posedge aclk) disable iff (!aresetn)
      seq_q == SQ_SETTLE && phase_end |=> seq_q == SQ_CHECK && tmr_q == $past(check_q);
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("window not after settle");

  property p_halt;
    @(posedge aclk) disable iff (!aresetn) ev_fail |=> seq_q == SQ_HALT ##1 disp_q.fail_flag;
  endproperty
  a_halt: assert property (p_halt) else $error("failure did not halt");

  property p_exit;
    @(posedge aclk) disable iff (!aresetn)
      seq_q == SQ_HALT && keys.exit_key |=> seq_q == SQ_IDLE && sts_q[EV_DONE];
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not abort");

  c_halt: cover property (@(posedge aclk) disable iff (!aresetn) ev_fail);
  c_done: cover property (@(posedge aclk) disable iff (!aresetn) ev_done && seq_q == SQ_CHECK);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq && rd_sts);
endmodule

//--- fpm_panel_model.sv
`timescale 1ns/1ps
// ****************************************
// Front keys and remote host model.
// ****************************************
module fpm_panel_model
(
  input wire logic aclk, // System clock.
  output fpm_pkg::fpm_keys_t keys, // Key pulses.
  output logic remote_req, // Remote takeover pulse.
  output logic [3:0] iface_fitted, // Fitted options.
  output logic limit_fail // Limit comparison.
);
  import fpm_pkg::*;
  initial
  begin
    keys = '0;
    remote_req = 1'b0;
    iface_fitted = 4'h5;
    limit_fail = 1'b0;
  end
  // One key for one cycle, so a press can never be counted twice.
  task automatic press(input int b);
    @(posedge aclk);
    keys <= fpm_keys_t'(10'h001 << b);
    @(posedge aclk);
    keys <= '0;
  endtask
  // The limit comparison is a level that changes just after an edge.
  task automatic limit(input logic v);
    @(posedge aclk);
    limit_fail <= v;
  endtask
  // A host takes control with a one-cycle request pulse.
  task automatic remote();
    @(posedge aclk);
    remote_req <= 1'b1;
    @(posedge aclk);
    remote_req <= 1'b0;
  endtask
endmodule

//--- test_front_panel_memory_sequence_ctrl.sv
`timescale 1ns/1ps
module test_front_panel_memory_sequence_ctrl;
  import fpm_pkg::*;
  logic aclk = 1'b0; // Clock.
  logic aresetn = 1'b0; // Reset, active low.
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Addresses.
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_q;
  logic [1:0] bresp, rresp, rsp_q;
  fpm_keys_t keys;
  logic remote_req, limit_fail, seen;
  logic [3:0] iface_fitted;
  fpm_disp_t disp_q;
  int errors = 0, cmp_count = 0, cycles = 0;
  fpm_front_panel #(.TICK_CYCLES(4)) fpm_front_panel_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .keys(keys), .remote_req(remote_req), .iface_fitted(iface_fitted),
    .limit_fail(limit_fail), .disp_q(disp_q), .irq(irq));
  fpm_panel_model fpm_panel_model_inst (.aclk(aclk), .keys(keys), .remote_req(remote_req),
    .iface_fitted(iface_fitted), .limit_fail(limit_fail));
  // ****************************************
  // Clock, timeout and report.
  // ****************************************
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  // The whole run needs well under a thousand cycles; a hang stops here.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits, then steps off the edge so registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic key(input int b);
    fpm_panel_model_inst.press(b);
    cyc(3);
  endtask
  // ****************************************
  // Register bus master.
  // ****************************************
  // Ready is sampled mid-cycle; nothing on the bus moves until the next edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    while (pb)
    begin
      @(negedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      pb = !bvalid;
      @(posedge aclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
      if (!pb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic pa, pr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    while (pr)
    begin
      @(negedge aclk);
      pa = pa && !arready;
      pr = !rvalid;
      rd_q = rdata;
      rsp_q = rresp;
      @(posedge aclk);
      if (!pa) arvalid <= 1'b0;
      if (!pr) rready <= 1'b0;
    end
    #1;
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_power_up();
    cyc(3);
    chk(32'(disp_q.all_on), 1);
    chk(32'(disp_q.iface_lamps), 15);
    chk(32'({disp_q.remote_indicator, disp_q.fail_flag}), 3);
    cyc(45);
    chk(32'(disp_q.all_on), 0);
    chk(32'(disp_q.iface_lamps), 5);
    chk(32'(disp_q.status_msg), 0);
    chk(32'({disp_q.upper_value, disp_q.lower_value}), 32'h0081);
  endtask
  // Both ends of the bank range and the top of the state range, including a press past each end.
  task automatic t_bank_state();
    key(8);
    chk(32'(disp_q.upper_value), 1);
    repeat (15) key(9);
    chk(32'(disp_q.upper_value), 15);
    repeat (10) key(7);
    chk(32'(disp_q.lower_value), 10);
    key(6);
    chk(32'(disp_q.lower_value), 9);
  endtask
  task automatic t_remote();
    fpm_panel_model_inst.remote();
    cyc(3);
    chk(32'(disp_q.remote_indicator), 1);
    key(6);
    chk(32'(disp_q.lower_value), 9);
    key(2);
    chk(32'(disp_q.remote_indicator), 0);
    rd(OFS_STATUS);
    chk(rd_q, 32'h0000_0004);
  endtask
  // Settle at its floor plus one, then a failing check window and an abort.
  task automatic t_auto();
    wr(OFS_MASK, 32'h0000_0001);
    key(0);
    chk(32'(disp_q.status_msg), 2);
    chk(32'({disp_q.upper_value, disp_q.lower_value}), 32'h050A);
    repeat (10) key(8);
    chk(32'(disp_q.upper_value), 1);
    key(9);
    chk(32'(disp_q.upper_value), 2);
    fpm_panel_model_inst.limit(1'b1);
    key(3);
    chk(32'({disp_q.running, disp_q.fail_flag}), 2);
    seen = 1'b0;
    repeat (16)
    begin
      cyc(1);
      seen = seen | disp_q.fail_flag;
    end
    chk(32'(seen), 1);
    chk(32'(irq), 1);
    rd(OFS_VIEW);
    chk(32'(rd_q[29:28]), 3);
    rd(OFS_STATUS);
    chk(rd_q, 32'h0000_0001);
    chk(32'(irq), 0);
    key(4);
    chk(32'(disp_q.running), 0);
    rd(OFS_STATUS);
    chk(rd_q, 32'h0000_0002);
    rd(8'h10);
    chk(32'(rsp_q), 32'(RESP_SLVERR));
    chk(rd_q, 32'h0000_0000);
  endtask
  // Halt on the first of two steps and resume, then a run with flagging off, then wake mode.
  task automatic t_resume();
    wr(OFS_CTRL, 32'h0000_0021);
    chk(32'(bresp), 32'(RESP_OKAY));
    key(3);
    cyc(20);
    rd(OFS_VIEW);
    chk(32'(rd_q[29:24]), 32'h0000_0030);
    fpm_panel_model_inst.limit(1'b0);
    key(5);
    cyc(30);
    chk(32'(disp_q.running), 1);
    rd(OFS_VIEW);
    chk(32'(rd_q[27:24]), 1);
    cyc(20);
    chk(32'(disp_q.running), 0);
    rd(OFS_STATUS);
    chk(rd_q, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0010);
    fpm_panel_model_inst.limit(1'b1);
    key(3);
    seen = 1'b0;
    repeat (60)
    begin
      cyc(1);
      seen = seen | disp_q.fail_flag;
    end
    chk(32'({seen, disp_q.running}), 0);
    rd(OFS_STATUS);
    chk(rd_q, 32'h0000_0002);
    key(1);
    chk(32'(disp_q.status_msg), 1);
    chk(32'({disp_q.upper_value, disp_q.lower_value}), 32'h0000_0789);
    key(4);
    chk(32'(disp_q.status_msg), 0);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_power_up();
    t_bank_state();
    t_remote();
    t_auto();
    t_resume();
    test_done();
  end
endmodule
